// file: src/icag_pkg.sv
// Package of constants and types for the control-register attribute guard
package icag_pkg;
	// Register byte offsets
	localparam logic [11:0] OFF_CONTROL_ZERO = 12'h020;
	localparam logic [11:0] OFF_CONTROL_ACK = 12'h024;
	localparam logic [11:0] OFF_CONTROL_ONE = 12'h028;
	localparam logic [11:0] OFF_CONTROL_TWO = 12'h02C;
	localparam logic [11:0] OFF_QUEUE_EXT = 12'h030;
	localparam logic [11:0] OFF_CAPS = 12'h034;
	// Control-zero field positions
	localparam int BIT_TRANS_EN = 0;
	localparam int BIT_PRIQ_EN = 1;
	localparam int BIT_EVTQ_EN = 2;
	localparam int BIT_CMDQ_EN = 3;
	localparam logic [3:0] CZ_MASK = 4'hF;
	// Control-two field positions
	localparam int BIT_HYP_REGIME = 0;
	localparam int BIT_REC_INV = 1;
	localparam int BIT_PRIV_TLB = 2;
	localparam int BIT_EXT_ATS = 3;
	// Control-one field layout
	localparam int TABLE_LSB = 6;
	localparam logic [11:0] TABLE_MASK = 12'hFC0;
	localparam logic [11:0] QUEUE_MASK = 12'h03F;
	// Enhanced queue count
	localparam int NUM_EQ = 4;
	// Reset values: fields documented undefined are given zero here
	localparam logic [3:0] CZ_RESET = 4'h0;
	localparam logic [3:0] CT_RESET = 4'h0;
	localparam logic [11:0] CO_RESET = 12'h000;
	localparam logic [5:0] TABLE_PRESET_VAL = 6'h15;
	localparam logic [5:0] QUEUE_PRESET_VAL = 6'h15;
	// Cycles from a control-zero write to its acknowledge copy update
	localparam int ACK_DELAY_CYC = 4;
	localparam logic [2:0] ACK_DELAY = 3'h4;

	// Capability flags
	typedef struct packed {
		logic table_attr_fixed_cap;
		logic queue_attr_fixed_cap;
		logic enhanced_queue_cap;
		logic ats_error_record_cap;
		logic broadcast_maint_cap;
		logic hyp_cap;
	} icag_caps_t;

	// Effective control values driven to the rest of the device
	typedef struct packed {
		logic translation_enable;
		logic extended_ats_event_record;
		logic private_tlb_maint;
		logic record_invalid_stream;
		logic hyp_host_regime_select;
		logic [5:0] table_attr;
		logic [5:0] queue_attr;
	} icag_eff_t;

	typedef enum logic [1:0] {
		ACK_IDLE = 2'b00,
		ACK_WAIT = 2'b01
	} icag_ack_state_t;
endpackage

// file: src/icag_ack_timer.sv
// Delay counter that publishes control-zero into its acknowledge copy
`timescale 1ns/1ps
module icag_ack_timer
	import icag_pkg::*;
(
	input wire logic pclk, // Register clock
	input wire logic presetn, // Async reset, active low
	input wire logic start, // Control-zero was written
	output logic done // One-cycle pulse when acknowledge updates
);
	icag_ack_state_t state_reg, state_next;
	logic [2:0] cnt_reg, cnt_next;

	// Restart on every new write so the ack always reflects the latest value
	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		done = 1'b0;
		case (state_reg)
			ACK_IDLE: begin
				if (start) begin
					state_next = ACK_WAIT;
					cnt_next = ACK_DELAY;
				end
			end
			ACK_WAIT: begin
				if (start) begin
					cnt_next = ACK_DELAY;
				end else if (cnt_reg == 3'h1) begin
					state_next = ACK_IDLE;
					done = 1'b1;
				end else begin
					cnt_next = cnt_reg - 3'h1;
				end
			end
			default: state_next = ACK_IDLE;
		endcase
	end

	// State registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= ACK_IDLE;
			cnt_reg <= 3'h0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
		end
	end
endmodule

// file: src/icag_held_ctrl.sv
// Register that holds the control-two values the device actually uses
`timescale 1ns/1ps
module icag_held_ctrl
	import icag_pkg::*;
(
	input wire logic pclk, // Register clock
	input wire logic presetn, // Async reset, active low
	input wire logic load, // Take the programmed value
	input wire logic [3:0] din, // Programmed control-two bits
	output logic [3:0] dout // Effective control-two bits
);
	// Effective value changes only at the enable acknowledge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dout <= CT_RESET;
		end else if (load) begin
			dout <= din;
		end
	end
endmodule

// file: src/icag_top.sv
// APB register guard for the non-secure control registers
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
// Notes on behaviour
// - With table attributes fixed by capability, writes never change effective table attributes.
// - Table-attribute writes are ignored while translation enable or its ack is set.
// - Queue-attribute writes need all queue enables and their acks at zero.
// - With the enhanced queue capability, enhanced queue enables and their acks must also be zero for queue writes.
// - Unfixed attributes reset to an unspecified value; software programs them first.
// - Bit 3 selects base or extended ATS/PRI event recording, if capable.
// - Private TLB bit zero joins broadcast invalidation; one may skip local entries.
// - Private TLB bit never affects secure or EL3 broadcast invalidations.
// - Invalid-stream bit zero suppresses bad stream events; one permits them.
// - Invalid-stream bit matters only for transactions arriving with translation enabled.
// - Hypervisor bit selects EL2 without ASID or the host EL2 regime with ASID.
// - Control-two writable only when translation enable and its ack are both zero.
// - Control-two writes during a pending enable acknowledge are ignored.
// - Control-two changes take effect by the next acknowledge of enable to one.
// - Broadcast invalidations after enable ack use the value held before it.
// - Control-two fields reset unspecified; bits 31 to 4 are reserved.
// - Translation enable zero bypasses streams; one checks configuration structures.
module icag_top
	import icag_pkg::*;
(
	input wire logic pclk, // APB clock
	input wire logic presetn, // APB reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [11:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error, unmapped address
	input wire logic [5:0] caps_pin, // Capability straps from pins
	output icag_eff_t eff, // Effective controls to the device
	output logic bypass_active // Streams bypass translation
);
	logic [5:0] caps_s1_reg, caps_s2_reg;
	icag_caps_t caps;
	logic [3:0] cz_reg, cz_ack_reg, ct_reg, ct_eff;
	logic [11:0] co_reg;
	logic [NUM_EQ-1:0] eq_en_reg, eq_ack_reg;
	logic [31:0] rdata_next;
	logic ack_pending_reg, ack_done, ack_start;
	logic trans_rise;

	// Straps come from pins, so synchronise them first
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			caps_s1_reg <= 6'h00;
			caps_s2_reg <= 6'h00;
		end else begin
			caps_s1_reg <= caps_pin;
			caps_s2_reg <= caps_s1_reg;
		end
	end
	assign caps = icag_caps_t'(caps_s2_reg);

	// APB decode: zero wait states, writes land on the access phase
	wire access = psel && penable;
	wire wr = access && pwrite;
	wire hit_cz = (paddr == OFF_CONTROL_ZERO);
	wire hit_ack = (paddr == OFF_CONTROL_ACK);
	wire hit_co = (paddr == OFF_CONTROL_ONE);
	wire hit_ct = (paddr == OFF_CONTROL_TWO);
	wire hit_eq = (paddr == OFF_QUEUE_EXT);
	wire hit_cap = (paddr == OFF_CAPS);
	wire mapped = hit_cz || hit_ack || hit_co || hit_ct || hit_eq || hit_cap;

	// Guard terms
	wire trans_quiet = !cz_reg[BIT_TRANS_EN] && !cz_ack_reg[BIT_TRANS_EN];
	wire base_q_quiet = !cz_reg[BIT_EVTQ_EN] && !cz_ack_reg[BIT_EVTQ_EN]
		&& !cz_reg[BIT_PRIQ_EN] && !cz_ack_reg[BIT_PRIQ_EN]
		&& !cz_reg[BIT_CMDQ_EN] && !cz_ack_reg[BIT_CMDQ_EN];
	wire eq_quiet = !caps.enhanced_queue_cap || ((eq_en_reg | eq_ack_reg) == '0);
	wire queue_quiet = base_q_quiet && eq_quiet;
	wire table_wr_ok = trans_quiet && !caps.table_attr_fixed_cap;
	wire queue_wr_ok = queue_quiet && !caps.queue_attr_fixed_cap;
	wire ct_wr_ok = trans_quiet && !ack_pending_reg;

	// Capability-absent bits are cleared on write
	wire [3:0] ct_cap_mask = {caps.ats_error_record_cap, caps.broadcast_maint_cap, 1'b1,
		caps.hyp_cap};
	assign ack_start = wr && hit_cz;
	assign trans_rise = ack_done && cz_reg[BIT_TRANS_EN] && !cz_ack_reg[BIT_TRANS_EN];

	// Control-zero and its acknowledge copy
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cz_reg <= CZ_RESET;
			cz_ack_reg <= CZ_RESET;
			ack_pending_reg <= 1'b0;
		end else begin
			if (ack_start) begin
				cz_reg <= pwdata[3:0] & CZ_MASK;
			end
			if (ack_done) begin
				cz_ack_reg <= cz_reg;
			end
			ack_pending_reg <= ack_start || (ack_pending_reg && !ack_done);
		end
	end

	// A new control-zero write always leaves an acknowledge pending
	property p_pending_set;
		@(posedge pclk) disable iff (!presetn)
		ack_start |=> ack_pending_reg;
	endproperty
	a_pending_set: assert property (p_pending_set) else $error("ack pending not raised");

	property p_ack_copy;
		@(posedge pclk) disable iff (!presetn)
		ack_done |=> (cz_ack_reg == $past(cz_reg));
	endproperty
	a_ack_copy: assert property (p_ack_copy) else $error("ack copy mismatch");

	icag_ack_timer icag_ack_timer_inst (
		.pclk(pclk),
		.presetn(presetn),
		.start(ack_start),
		.done(ack_done)
	);

	// Control-one attribute fields with separate guards
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			co_reg <= CO_RESET;
		end else if (wr && hit_co) begin
			co_reg <= ((table_wr_ok ? pwdata[11:0] : co_reg) & TABLE_MASK)
				| ((queue_wr_ok ? pwdata[11:0] : co_reg) & QUEUE_MASK);
		end
	end

	// Accepted attribute writes must land field by field
	property p_table_wr;
		@(posedge pclk) disable iff (!presetn)
		(wr && hit_co && table_wr_ok) |=> (co_reg[11:6] == $past(pwdata[11:6]));
	endproperty
	a_table_wr: assert property (p_table_wr) else $error("table attr write lost");

	property p_queue_wr;
		@(posedge pclk) disable iff (!presetn)
		(wr && hit_co && queue_wr_ok) |=> (co_reg[5:0] == $past(pwdata[5:0]));
	endproperty
	a_queue_wr: assert property (p_queue_wr) else $error("queue attr write lost");

	// The acknowledge side of an enhanced queue locks the field as well
	property p_eq_ack_guard;
		@(posedge pclk) disable iff (!presetn)
		(wr && hit_co && caps.enhanced_queue_cap && (eq_ack_reg != '0)) |=> $stable(co_reg[5:0]);
	endproperty
	a_eq_ack_guard: assert property (p_eq_ack_guard) else $error("queue attr moved, eq ack");

	// Control-two programmed value and enhanced queue states
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ct_reg <= CT_RESET;
			eq_en_reg <= '0;
			eq_ack_reg <= '0;
		end else begin
			if (wr && hit_ct && ct_wr_ok) begin
				ct_reg <= pwdata[3:0] & ct_cap_mask;
			end
			if (wr && hit_eq) begin
				eq_en_reg <= pwdata[NUM_EQ-1:0];
			end
			eq_ack_reg <= eq_en_reg;
		end
	end

	// The extended ATS bit never takes a written one while its capability is absent
	property p_ct_absent;
		@(posedge pclk) disable iff (!presetn)
		(wr && hit_ct && ct_wr_ok && !caps.ats_error_record_cap) |=> !ct_reg[BIT_EXT_ATS];
	endproperty
	a_ct_absent: assert property (p_ct_absent) else $error("absent bit took a write");

	// Effective copy only moves when enable acknowledges to one
	icag_held_ctrl icag_held_ctrl_inst (
		.pclk(pclk),
		.presetn(presetn),
		.load(trans_rise),
		.din(ct_reg),
		.dout(ct_eff)
	);

	// Read data mux, reserved bits read zero
	always_comb begin
		rdata_next = 32'h00000000;
		if (hit_cz) begin
			rdata_next[3:0] = cz_reg;
		end else if (hit_ack) begin
			rdata_next[3:0] = cz_ack_reg;
		end else if (hit_co) begin
			rdata_next[11:0] = caps.table_attr_fixed_cap ?
				{TABLE_PRESET_VAL, co_reg[5:0]} : co_reg;
			if (caps.queue_attr_fixed_cap) begin
				rdata_next[5:0] = QUEUE_PRESET_VAL;
			end
		end else if (hit_ct) begin
			rdata_next[3:0] = ct_reg;
		end else if (hit_eq) begin
			rdata_next[NUM_EQ-1:0] = eq_en_reg;
			rdata_next[NUM_EQ+15:16] = eq_ack_reg;
		end else if (hit_cap) begin
			rdata_next[5:0] = caps_s2_reg;
		end
	end

	// Readback follows the stored value and the fixed table preset
	property p_ct_read;
		@(posedge pclk) disable iff (!presetn)
		(psel && !penable && !pwrite && hit_ct) |=> (prdata[3:0] == $past(ct_reg));
	endproperty
	a_ct_read: assert property (p_ct_read) else $error("control two readback wrong");

	property p_table_read;
		@(posedge pclk) disable iff (!presetn)
		(psel && !penable && !pwrite && hit_co && caps.table_attr_fixed_cap)
			|=> (prdata[11:6] == TABLE_PRESET_VAL);
	endproperty
	a_table_read: assert property (p_table_read) else $error("preset table readback wrong");

	// APB outputs and effective controls, all registered
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
			eff <= '0;
			bypass_active <= 1'b1;
		end else begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !mapped;
			prdata <= (psel && !penable && !pwrite) ? rdata_next : 32'h00000000;
			eff.translation_enable <= cz_ack_reg[BIT_TRANS_EN];
			bypass_active <= !cz_ack_reg[BIT_TRANS_EN];
			eff.extended_ats_event_record <= ct_eff[BIT_EXT_ATS];
			eff.private_tlb_maint <= ct_eff[BIT_PRIV_TLB];
			eff.record_invalid_stream <= ct_eff[BIT_REC_INV]
				&& cz_ack_reg[BIT_TRANS_EN];
			eff.hyp_host_regime_select <= ct_eff[BIT_HYP_REGIME];
			eff.table_attr <= caps.table_attr_fixed_cap ? TABLE_PRESET_VAL
				: co_reg[11:TABLE_LSB];
			eff.queue_attr <= caps.queue_attr_fixed_cap ? QUEUE_PRESET_VAL : co_reg[5:0];
		end
	end

	// Each control-two effective output is the held value one edge later; invalid-stream recording also needs the enable ack
	property p_bypass_follow;
		@(posedge pclk) disable iff (!presetn)
		1'b1 |=> (bypass_active == !$past(cz_ack_reg[BIT_TRANS_EN]));
	endproperty
	a_bypass_follow: assert property (p_bypass_follow) else $error("bypass off ack");

	property p_ext_ats;
		@(posedge pclk) disable iff (!presetn)
		1'b1 |=> (eff.extended_ats_event_record == $past(ct_eff[BIT_EXT_ATS]));
	endproperty
	a_ext_ats: assert property (p_ext_ats) else $error("ats record select wrong");

	property p_priv;
		@(posedge pclk) disable iff (!presetn)
		1'b1 |=> (eff.private_tlb_maint == $past(ct_eff[BIT_PRIV_TLB]));
	endproperty
	a_priv: assert property (p_priv) else $error("private maint wrong");

	property p_hyp;
		@(posedge pclk) disable iff (!presetn)
		1'b1 |=> (eff.hyp_host_regime_select == $past(ct_eff[BIT_HYP_REGIME]));
	endproperty
	a_hyp: assert property (p_hyp) else $error("hypervisor regime wrong");

	property p_rec_en;
		@(posedge pclk) disable iff (!presetn)
		(ct_eff[BIT_REC_INV] && cz_ack_reg[BIT_TRANS_EN]) |=> eff.record_invalid_stream;
	endproperty
	a_rec_en: assert property (p_rec_en) else $error("recording not permitted");

	// Checks
	property p_ct_guard;
		@(posedge pclk) disable iff (!presetn)
		(wr && hit_ct && !ct_wr_ok) |=> $stable(ct_reg);
	endproperty
	a_ct_guard: assert property (p_ct_guard) else $error("control two changed while guarded");

	property p_ct_pending;
		@(posedge pclk) disable iff (!presetn)
		(wr && hit_ct && ack_pending_reg) |=> (ct_reg == $past(ct_reg));
	endproperty
	a_ct_pending: assert property (p_ct_pending) else $error("write taken during ack");

	property p_table_guard;
		@(posedge pclk) disable iff (!presetn)
		(wr && hit_co && !trans_quiet) |=> (co_reg[11:6] == $past(co_reg[11:6]));
	endproperty
	a_table_guard: assert property (p_table_guard) else $error("table attr changed");

	property p_queue_guard;
		@(posedge pclk) disable iff (!presetn)
		(wr && hit_co && !base_q_quiet) |=> (co_reg[5:0] == $past(co_reg[5:0]));
	endproperty
	a_queue_guard: assert property (p_queue_guard) else $error("queue attr changed");

	property p_eq_guard;
		@(posedge pclk) disable iff (!presetn)
		(wr && hit_co && caps.enhanced_queue_cap && (eq_en_reg != '0))
			|=> $stable(co_reg[5:0]);
	endproperty
	a_eq_guard: assert property (p_eq_guard) else $error("queue attr changed, eq on");

	property p_table_fixed;
		@(posedge pclk) disable iff (!presetn)
		caps.table_attr_fixed_cap ##2 caps.table_attr_fixed_cap
			|-> (eff.table_attr == TABLE_PRESET_VAL);
	endproperty
	a_table_fixed: assert property (p_table_fixed) else $error("fixed table attr moved");

	property p_eff_hold;
		@(posedge pclk) disable iff (!presetn)
		!trans_rise |=> (ct_eff == $past(ct_eff));
	endproperty
	a_eff_hold: assert property (p_eff_hold) else $error("effective value moved early");

	property p_eff_load;
		@(posedge pclk) disable iff (!presetn)
		trans_rise |=> (ct_eff == $past(ct_reg)) ##1 (eff.private_tlb_maint == ct_eff[2]);
	endproperty
	a_eff_load: assert property (p_eff_load) else $error("value not applied on ack");

	property p_recinv;
		@(posedge pclk) disable iff (!presetn)
		!cz_ack_reg[BIT_TRANS_EN] |=> !eff.record_invalid_stream;
	endproperty
	a_recinv: assert property (p_recinv) else $error("recording while disabled");

	property p_reserved;
		@(posedge pclk) disable iff (!presetn)
		(psel && !penable && !pwrite && hit_ct) |=> (prdata[31:4] == 28'h0000000);
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bits nonzero");

	property p_bypass;
		@(posedge pclk) disable iff (!presetn)
		bypass_active |-> !eff.translation_enable;
	endproperty
	a_bypass: assert property (p_bypass) else $error("bypass and enable both set");
endmodule

// file: bench/icag_top_test.sv
// Self-checking bench for the control-register attribute guard
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_fail++; $display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module icag_top_test
	import icag_pkg::*;
;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [5:0] caps_pin = 6'h00;
	icag_eff_t eff;
	logic bypass_active;
	int n_fail = 0;
	int cmp_count = 0;
	int cyc = 0;
	logic [31:0] q;
	logic e;

	icag_top icag_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .caps_pin(caps_pin), .eff(eff), .bypass_active(bypass_active));

	// 200 MHz register clock
	always #2.5 pclk = ~pclk;

	// Hang guard: the whole run needs well under a thousand cycles
	always @(posedge pclk) begin
		cyc++;
		if (cyc >= 5000) begin
			n_fail++;
			$display("ERROR t=%0t timeout", $time);
			end_sim();
		end
	end

	task automatic end_sim();
		$display("Checks %0d, mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// One APB transfer; entered just after an edge, leaves one idle edge behind it
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic ticks(input int n);
		repeat (n) @(posedge pclk);
	endtask

	// Straps pass two sync flops, so allow a few edges before they count
	task automatic set_caps(input logic [5:0] c);
		caps_pin <= c;
		ticks(4);
	endtask

	// Write control-zero and let the acknowledge copy settle
	task automatic cz(input logic [31:0] d);
		wr(OFF_CONTROL_ZERO, d);
		ticks(ACK_DELAY_CYC + 3);
	endtask

	task automatic t_reset();
		apb(1'b0, OFF_CONTROL_TWO, 32'h0);
		`CHK(q, 32'h0000_0000)
		`CHK(bypass_active, 1'b1)
		`CHK(eff, 17'h00000)
		apb(1'b0, 12'h100, 32'h0);
		`CHK(e, 1'b1)
		$display("reset test done");
	endtask

	task automatic t_absent();
		set_caps(6'h00);
		wr(OFF_CONTROL_TWO, 32'hFFFF_FFFF);
		apb(1'b0, OFF_CONTROL_TWO, 32'h0);
		`CHK(q, 32'h0000_0002)
		$display("absent-capability test done");
	endtask

	task automatic t_enable();
		set_caps(6'h07);
		wr(OFF_CONTROL_TWO, 32'hFFFF_FFFF);
		apb(1'b0, OFF_CONTROL_TWO, 32'h0);
		`CHK(q, 32'h0000_000F)
		cz(32'h1);
		apb(1'b0, OFF_CONTROL_ACK, 32'h0);
		`CHK(q[0], 1'b1)
		`CHK(eff.translation_enable, 1'b1)
		`CHK(bypass_active, 1'b0)
		`CHK(eff.extended_ats_event_record, 1'b1)
		`CHK(eff.private_tlb_maint, 1'b1)
		`CHK(eff.record_invalid_stream, 1'b1)
		`CHK(eff.hyp_host_regime_select, 1'b1)
		// Enabled: control-two must hold its value
		wr(OFF_CONTROL_TWO, 32'h0);
		apb(1'b0, OFF_CONTROL_TWO, 32'h0);
		`CHK(q, 32'h0000_000F)
		`CHK(eff.private_tlb_maint, 1'b1)
		cz(32'h0);
		`CHK(bypass_active, 1'b1)
		$display("enable test done");
	endtask

	// Enable then disable at once: ack never rises, but an update is still pending
	task automatic t_pending();
		wr(OFF_CONTROL_ZERO, 32'h1);
		wr(OFF_CONTROL_ZERO, 32'h0);
		wr(OFF_CONTROL_TWO, 32'h5);
		apb(1'b0, OFF_CONTROL_TWO, 32'h0);
		`CHK(q, 32'h0000_000F)
		ticks(ACK_DELAY_CYC + 3);
		wr(OFF_CONTROL_TWO, 32'h5);
		apb(1'b0, OFF_CONTROL_TWO, 32'h0);
		`CHK(q, 32'h0000_0005)
		`CHK(eff.extended_ats_event_record, 1'b1)
		// Software re-enables before relying on the new ATS recording bit
		cz(32'h1);
		`CHK(eff.extended_ats_event_record, 1'b0)
		`CHK(eff.record_invalid_stream, 1'b0)
		`CHK(eff.private_tlb_maint, 1'b1)
		cz(32'h0);
		$display("pending test done");
	endtask

	task automatic t_attr();
		set_caps(6'h00);
		wr(OFF_CONTROL_ONE, 32'h0000_0A5C);
		apb(1'b0, OFF_CONTROL_ONE, 32'h0);
		`CHK(q, 32'h0000_0A5C)
		cz(32'h1);
		wr(OFF_CONTROL_ONE, 32'h0000_0FFF);
		apb(1'b0, OFF_CONTROL_ONE, 32'h0);
		`CHK(q, 32'h0000_0A7F)
		// Each control-zero queue enable alone must lock the queue field
		for (int i = 1; i <= 3; i++) begin
			cz(32'h1 << i);
			wr(OFF_CONTROL_ONE, 32'h0);
			apb(1'b0, OFF_CONTROL_ONE, 32'h0);
			`CHK(q, 32'h0000_003F)
		end
		cz(32'h0);
		set_caps(6'h08);
		wr(OFF_QUEUE_EXT, 32'h1);
		apb(1'b0, OFF_QUEUE_EXT, 32'h0);
		`CHK(q, 32'h0001_0001)
		wr(OFF_CONTROL_ONE, 32'h0);
		apb(1'b0, OFF_CONTROL_ONE, 32'h0);
		`CHK(q, 32'h0000_003F)
		wr(OFF_QUEUE_EXT, 32'h0);
		ticks(3);
		wr(OFF_CONTROL_ONE, 32'h0);
		apb(1'b0, OFF_CONTROL_ONE, 32'h0);
		`CHK(q, 32'h0000_0000)
		$display("attribute guard test done");
	endtask

	task automatic t_preset();
		set_caps(6'h30);
		apb(1'b0, OFF_CONTROL_ONE, 32'h0);
		`CHK(q, 32'h0000_0555)
		wr(OFF_CONTROL_ONE, 32'h0);
		ticks(3);
		`CHK(eff.table_attr, TABLE_PRESET_VAL)
		`CHK(eff.queue_attr, QUEUE_PRESET_VAL)
		apb(1'b0, OFF_CAPS, 32'h0);
		`CHK(q, 32'h0000_0030)
		$display("preset test done");
	endtask

	// Main sequence
	initial begin
		ticks(20);
		presetn <= 1'b1;
		ticks(3);
		t_reset();
		t_absent();
		t_enable();
		t_pending();
		t_attr();
		t_preset();
		end_sim();
	end
endmodule
